/* shared/lookup_table_pkg.sv */
// Package with register map, field layout and timing constants of the lookup table access block
package lookup_table_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] LOOKUP_TABLE_COMMAND_ADDR    = 16'h1800;
  localparam logic [ADDR_W-1:0] LOOKUP_WRITE_DATA_LOW_ADDR   = 16'h1801;
  localparam logic [ADDR_W-1:0] LOOKUP_WRITE_DATA_HIGH_ADDR  = 16'h1802;
  localparam logic [ADDR_W-1:0] LOOKUP_READ_DATA_LOW_ADDR    = 16'h1803;
  localparam logic [ADDR_W-1:0] LOOKUP_READ_DATA_HIGH_ADDR   = 16'h1804;
  localparam logic [ADDR_W-1:0] LOOKUP_COMMAND_STATUS_ADDR   = 16'h1808;
  localparam logic [DATA_W-1:0] ZERO_WORD                    = 32'h00000000;
  // Command and status bits
  localparam int CMD_MAKE_BIT  = 2;
  localparam int CMD_FIRST_BIT = 1;
  localparam int CMD_NEXT_BIT  = 0;
  localparam int STS_MAKE_PENDING_BIT = 0;
  localparam int STS_READ_PENDING_BIT = 1;
  // High data word fields
  localparam int HI_VALID_BIT  = 26;
  localparam int HI_AGE_BIT    = 25;
  localparam int HI_STATIC_BIT = 24;
  localparam int HI_FILTER_BIT = 23;
  localparam int HI_MULTI_BIT  = 18;
  localparam int HI_PORT_LSB   = 16;
  localparam int HI_USED_W     = 27;
  localparam int MAC_HI_W      = 16;
  localparam int ENTRY_W       = DATA_W + HI_USED_W;
  localparam logic [DATA_W-1:0] HI_WRITE_MASK = 32'h07FFFFFF;
  localparam logic [DATA_W-1:0] CMD_MASK      = 32'h00000007;
  // Aging: entry removed after 5 to 10 min; tick every 5 min, two ticks to expire
  localparam longint AGE_PERIOD_S   = 300;
  localparam longint CLK_HZ         = 25000000;
  localparam longint AGE_TICK_CYCLES = AGE_PERIOD_S * CLK_HZ;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SEARCH = 2'b01,
    ST_WRITE  = 2'b11,
    ST_AGE    = 2'b10
  } table_state_t;
endpackage

/* core/lookup_entry_match.sv */
// Compare of one stored table entry against a MAC address
`timescale 1ns/100ps
`default_nettype none
module lookup_entry_match #(
  parameter int ENTRY_W = 59,
  parameter int MAC_W   = 48
) (
  // Entry and key
  input  wire logic [ENTRY_W-1:0] entry_in,
  input  wire logic               valid_in,
  input  wire logic [MAC_W-1:0]   mac_in,
  // Result
  output logic                    hit_out
);
  assign hit_out = valid_in && (entry_in[MAC_W-1:0] == mac_in);
endmodule
`default_nettype wire

/* core/address_table_manual_access.sv */
// Register bank for manual access to the MAC address lookup table
// Operation
// - Make entry stores both staged data words; table picks location.
// - Make entry also replaces or removes an existing entry.
// - Writing zero to a command bit does nothing.
// - Make pending shows whether make is in progress.
// - Get first resets read pointer, finds first valid entry, loads read data.
// - Get next advances to the next valid entry, loads read data.
// - Low write word holds first 32 MAC bits; bit 0 is multicast.
// - Bit 26 valid: set validates, clear invalidates same-MAC entry.
// - Bit 24 static blocks aging; otherwise removed after 5 to 10 minutes.
// - Bit 23 filter discards frames whose destination matches.
// - Bits 18:16 port; bit 18 set means multiple ports.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module address_table_manual_access
  import lookup_table_pkg::*;
#(
  parameter int     DEPTH      = 512,
  parameter longint AGE_CYCLES = AGE_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                                  sys_clk_in,
  input  wire logic                                  nrst_in,
  // Register port
  input  wire logic [lookup_table_pkg::ADDR_W-1:0]   reg_addr_in,
  input  wire logic [lookup_table_pkg::DATA_W-1:0]   reg_wdata_in,
  input  wire logic                                  reg_wr_in,
  input  wire logic                                  reg_rd_in,
  output logic      [lookup_table_pkg::DATA_W-1:0]   reg_rdata_out,
  // Switch lookups: destination check and source refresh
  input  wire logic [47:0]                           dest_mac_in,
  input  wire logic                                  src_seen_in,
  input  wire logic [47:0]                           src_mac_in,
  output logic                                       dest_filter_out,
  output logic                                       dest_hit_out,
  output logic      [2:0]                            dest_port_out
);
  import lookup_table_pkg::*;

  localparam int IDX_W = $clog2(DEPTH);
  localparam int MAC_W = DATA_W + MAC_HI_W;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DEPTH - 1);
  localparam logic [IDX_W-1:0] IDX_ZERO = '0;
  localparam logic [1:0]       AGE_FULL = 2'b10;

  logic [ENTRY_W-1:0] table_q [DEPTH];
  logic [1:0]         age_q   [DEPTH];
  logic [DEPTH-1:0]   dest_hit_vec, src_hit_vec, key_hit_vec;

  logic [DATA_W-1:0]   wr_low_q, wr_high_q, rd_low_q, rd_high_q, cmd_q;
  logic                make_pending_q, read_pending_q;
  table_state_t        state_q;
  logic [IDX_W-1:0]    ptr_q, age_idx_q;
  logic [63:0]         age_cnt_q;
  logic                age_tick_q;

  wire logic [MAC_W-1:0] key_mac = {wr_high_q[MAC_HI_W-1:0], wr_low_q};
  wire logic [ENTRY_W-1:0] new_entry = {wr_high_q[HI_USED_W-1:0], wr_low_q};
  wire logic cmd_wr = reg_wr_in && reg_addr_in == LOOKUP_TABLE_COMMAND_ADDR;
  // Only a one going in starts an action; zeros are ignored
  wire logic make_go  = cmd_wr && reg_wdata_in[CMD_MAKE_BIT];
  wire logic first_go = cmd_wr && reg_wdata_in[CMD_FIRST_BIT];
  wire logic next_go  = cmd_wr && reg_wdata_in[CMD_NEXT_BIT];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_cmp
      lookup_entry_match #(.ENTRY_W(ENTRY_W), .MAC_W(MAC_W)) u_dst (
        .entry_in(table_q[g]), .valid_in(table_q[g][MAC_W+HI_VALID_BIT-MAC_HI_W]),
        .mac_in(dest_mac_in), .hit_out(dest_hit_vec[g]));
      lookup_entry_match #(.ENTRY_W(ENTRY_W), .MAC_W(MAC_W)) u_src (
        .entry_in(table_q[g]), .valid_in(table_q[g][MAC_W+HI_VALID_BIT-MAC_HI_W]),
        .mac_in(src_mac_in), .hit_out(src_hit_vec[g]));
      lookup_entry_match #(.ENTRY_W(ENTRY_W), .MAC_W(MAC_W)) u_key (
        .entry_in(table_q[g]), .valid_in(table_q[g][MAC_W+HI_VALID_BIT-MAC_HI_W]),
        .mac_in(key_mac), .hit_out(key_hit_vec[g]));
    end
  endgenerate

  function automatic logic entry_valid(input logic [ENTRY_W-1:0] e);
    entry_valid = e[DATA_W+HI_VALID_BIT];
  endfunction

  // Location chosen by the table: matching entry first, else first free slot
  logic [IDX_W-1:0] place_idx;
  logic             place_ok;
  always_comb begin
    place_idx = IDX_ZERO;
    place_ok  = 1'b0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (!entry_valid(table_q[i])) begin
        place_idx = IDX_W'(i);
        place_ok  = 1'b1;
      end
    end
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (key_hit_vec[i]) begin
        place_idx = IDX_W'(i);
        place_ok  = 1'b1;
      end
    end
  end

  // Staging registers
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      wr_low_q  <= ZERO_WORD;
      wr_high_q <= ZERO_WORD;
    end else if (reg_wr_in) begin
      if (reg_addr_in == LOOKUP_WRITE_DATA_LOW_ADDR)
        wr_low_q <= reg_wdata_in;
      if (reg_addr_in == LOOKUP_WRITE_DATA_HIGH_ADDR)
        wr_high_q <= reg_wdata_in & HI_WRITE_MASK;
    end
  end

  // Command register holds bits as written; software clears them
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in)
      cmd_q <= ZERO_WORD;
    else if (cmd_wr)
      cmd_q <= reg_wdata_in & CMD_MASK;
  end

  // Aging period tick
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      age_cnt_q  <= '0;
      age_tick_q <= 1'b0;
    end else begin
      // Tick stays pending until the sequencer is free to sweep, so no aging period is lost
      age_tick_q <= (age_cnt_q == 64'(AGE_CYCLES - 1)) ||
                    (age_tick_q && !(state_q == ST_IDLE && !make_go && !first_go && !next_go));
      age_cnt_q  <= (age_cnt_q == 64'(AGE_CYCLES - 1)) ? '0 : age_cnt_q + 64'h1;
    end
  end

  // Sequencer: make, search and aging sweep share the table port
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      state_q        <= ST_IDLE;
      make_pending_q <= 1'b0;
      read_pending_q <= 1'b0;
      ptr_q          <= IDX_ZERO;
      age_idx_q      <= IDX_ZERO;
      rd_low_q       <= ZERO_WORD;
      rd_high_q      <= ZERO_WORD;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (make_go) begin
            make_pending_q <= 1'b1;
            state_q        <= ST_WRITE;
          end else if (first_go) begin
            ptr_q          <= IDX_ZERO;
            read_pending_q <= 1'b1;
            state_q        <= ST_SEARCH;
          end else if (next_go) begin
            ptr_q          <= (ptr_q == LAST_IDX) ? IDX_ZERO : ptr_q + IDX_W'(1);
            read_pending_q <= 1'b1;
            state_q        <= ST_SEARCH;
          end else if (age_tick_q) begin
            age_idx_q <= IDX_ZERO;
            state_q   <= ST_AGE;
          end
        end
        ST_WRITE: begin
          make_pending_q <= 1'b0;
          state_q        <= ST_IDLE;
        end
        ST_SEARCH: begin
          if (entry_valid(table_q[ptr_q])) begin
            rd_low_q       <= table_q[ptr_q][DATA_W-1:0];
            rd_high_q      <= DATA_W'(table_q[ptr_q][ENTRY_W-1:DATA_W]);
            read_pending_q <= 1'b0;
            state_q        <= ST_IDLE;
          end else if (ptr_q == LAST_IDX) begin
            // End of table: an all-zero answer, valid bit clear, marks it
            rd_low_q       <= ZERO_WORD;
            rd_high_q      <= ZERO_WORD;
            read_pending_q <= 1'b0;
            state_q        <= ST_IDLE;
          end else
            ptr_q <= ptr_q + IDX_W'(1);
        end
        ST_AGE: begin
          age_idx_q <= age_idx_q + IDX_W'(1);
          if (age_idx_q == LAST_IDX)
            state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Table store and age counters
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        table_q[i] <= '0;
        age_q[i]   <= 2'b00;
      end
    end else begin
      if (state_q == ST_WRITE && (place_ok || !wr_high_q[HI_VALID_BIT])) begin
        // Clearing valid removes the same-MAC entry, manual or learned
        if (key_hit_vec[place_idx] || wr_high_q[HI_VALID_BIT]) begin
          table_q[place_idx] <= new_entry;
          age_q[place_idx]   <= 2'b00;
        end
      end else if (state_q == ST_AGE) begin
        if (entry_valid(table_q[age_idx_q]) && !table_q[age_idx_q][DATA_W+HI_STATIC_BIT]) begin
          if (age_q[age_idx_q] == AGE_FULL - 2'b01)
            table_q[age_idx_q][DATA_W+HI_VALID_BIT] <= 1'b0;
          age_q[age_idx_q] <= age_q[age_idx_q] + 2'b01;
        end
      end
      // A source seen during a sweep still counts; placed last so it beats the sweep's increment
      for (int i = 0; i < DEPTH; i++)
        if (src_seen_in && src_hit_vec[i])
          age_q[i] <= 2'b00;
    end
  end

  // Destination lookup for the forwarding path
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      dest_filter_out <= 1'b0;
      dest_hit_out    <= 1'b0;
      dest_port_out   <= 3'b000;
    end else begin
      dest_hit_out    <= |dest_hit_vec;
      dest_filter_out <= 1'b0;
      dest_port_out   <= 3'b000;
      for (int i = 0; i < DEPTH; i++)
        if (dest_hit_vec[i]) begin
          dest_filter_out <= table_q[i][DATA_W+HI_FILTER_BIT];
          dest_port_out   <= table_q[i][DATA_W+HI_PORT_LSB +: 3];
        end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in)
      reg_rdata_out <= ZERO_WORD;
    else if (reg_rd_in) begin
      unique case (reg_addr_in)
        LOOKUP_TABLE_COMMAND_ADDR:   reg_rdata_out <= cmd_q;
        LOOKUP_WRITE_DATA_LOW_ADDR:  reg_rdata_out <= wr_low_q;
        LOOKUP_WRITE_DATA_HIGH_ADDR: reg_rdata_out <= wr_high_q;
        LOOKUP_READ_DATA_LOW_ADDR:   reg_rdata_out <= rd_low_q;
        LOOKUP_READ_DATA_HIGH_ADDR:  reg_rdata_out <= rd_high_q;
        LOOKUP_COMMAND_STATUS_ADDR:
          reg_rdata_out <= DATA_W'({read_pending_q, make_pending_q});
        default:                     reg_rdata_out <= ZERO_WORD;
      endcase
    end else
      reg_rdata_out <= ZERO_WORD;
  end

  // Make pending rises the cycle after make is written and falls one later
  property make_pend_p;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      (make_go && state_q == ST_IDLE) |=> make_pending_q ##1 !make_pending_q;
  endproperty
  make_pending_a: assert property (make_pend_p) else $error("make pending sequence wrong");

  zero_write_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (cmd_wr && reg_wdata_in[2:0] == 3'b000 && state_q == ST_IDLE && !age_tick_q) |=> state_q == ST_IDLE)
    else $error("zero command started an action");

  sequence first_start_s;
    first_go && !make_go && state_q == ST_IDLE;
  endsequence
  first_ptr_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    first_start_s |=> ptr_q == IDX_ZERO && read_pending_q)
    else $error("get first did not rewind pointer");

  search_end_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (state_q == ST_SEARCH) |-> ##[1:600] !read_pending_q)
    else $error("table search did not finish");

  filter_out_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !(|dest_hit_vec) |=> !dest_filter_out && !dest_hit_out)
    else $error("filter without hit");

  stage_high_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == LOOKUP_WRITE_DATA_HIGH_ADDR) |=> wr_high_q[31:27] == 5'h00)
    else $error("reserved high bits stored");

  stage_low_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == LOOKUP_WRITE_DATA_LOW_ADDR) |=> key_mac[0] == $past(reg_wdata_in[0]))
    else $error("multicast bit misplaced");

  write_done_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (state_q == ST_WRITE && place_ok && wr_high_q[HI_VALID_BIT]) |=> table_q[$past(place_idx)] == $past(new_entry))
    else $error("make entry not stored");
endmodule
`default_nettype wire

/* sim/address_table_manual_access_tb_top.sv */
// Self-checking bench for the lookup table register bank
`timescale 1ns/100ps
`default_nettype none
module address_table_manual_access_tb_top;
  import lookup_table_pkg::*;
  logic        sys_clk_in    = 1'b0;
  logic        nrst_in       = 1'b0;
  logic [15:0] reg_addr_in   = 16'h0000;
  logic [31:0] reg_wdata_in  = 32'h00000000;
  logic        reg_wr_in     = 1'b0;
  logic        reg_rd_in     = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [47:0] dest_mac_in   = 48'h000000000000;
  logic        src_seen_in   = 1'b0;
  logic [47:0] src_mac_in    = 48'h000000000000;
  logic        dest_filter_out;
  logic        dest_hit_out;
  logic [2:0]  dest_port_out;
  logic        rd_chk        = 1'b0;
  logic        rd_chk_d      = 1'b0;
  logic        rd_any_d      = 1'b0;
  logic [31:0] last_rdata    = 32'h00000000;
  logic        lk_chk        = 1'b0;
  logic [4:0]  lk_exp;
  logic [4:0]  lk_q[$];
  logic [31:0] exp_q[$];
  logic [31:0] lo_a, lo_b, lo_c, lo_d, lo_r, hi_a, hi_b, hi_c, hi_d;
  integer      seed          = 34;
  int          fails         = 0;
  int          total_checks  = 0;
  int          i;

  address_table_manual_access #(.DEPTH(8), .AGE_CYCLES(100)) address_table_manual_access_i (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .dest_mac_in(dest_mac_in),
    .src_seen_in(src_seen_in), .src_mac_in(src_mac_in), .dest_filter_out(dest_filter_out),
    .dest_hit_out(dest_hit_out), .dest_port_out(dest_port_out));

  always #20 sys_clk_in = ~sys_clk_in;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken at the next edge
  always @(posedge sys_clk_in) begin
    if (rd_chk_d) check(reg_rdata_out, exp_q.pop_front());
    if (lk_chk) begin
      lk_exp = lk_q.pop_front();
      check({31'h0, dest_hit_out}, {31'h0, lk_exp[4]});
      check({31'h0, dest_filter_out}, {31'h0, lk_exp[3]});
      if (lk_exp[4]) check({29'h0, dest_port_out}, {29'h0, lk_exp[2:0]});
    end
    if (rd_any_d) last_rdata <= reg_rdata_out;
    rd_chk_d <= reg_rd_in & rd_chk;
    rd_any_d <= reg_rd_in;
  end

  // One bus cycle; strobes may follow each other with no gap since the next call reassigns them
  task automatic bus(input logic w, input logic r, input logic c, input logic [15:0] a,
                     input logic [31:0] d);
    reg_wr_in    <= w;
    reg_rd_in    <= r;
    rd_chk       <= c;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    if (r && c) exp_q.push_back(d);
    @(posedge sys_clk_in);
  endtask

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 1'b0, 16'h0000, 32'h00000000);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, 1'b0, a, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, 1'b1, 1'b1, a, exp);
  endtask

  task automatic make(input logic [31:0] lo, input logic [31:0] hi);
    wr(LOOKUP_WRITE_DATA_LOW_ADDR, lo);
    wr(LOOKUP_WRITE_DATA_HIGH_ADDR, hi);
    wr(LOOKUP_TABLE_COMMAND_ADDR, 32'h00000004);
    rd(LOOKUP_COMMAND_STATUS_ADDR, 32'h00000001);
    rd(LOOKUP_COMMAND_STATUS_ADDR, 32'h00000000);
    rd(LOOKUP_TABLE_COMMAND_ADDR, 32'h00000004);
    wr(LOOKUP_TABLE_COMMAND_ADDR, 32'h00000000);
    idle(2);
  endtask

  // Polls the search flag under a bound, then reads the low and the high data word in turn
  task automatic get(input logic [31:0] cmd, input logic [31:0] lo, input logic [31:0] hi);
    int n;
    wr(LOOKUP_TABLE_COMMAND_ADDR, cmd);
    n = 0;
    do begin
      bus(1'b0, 1'b1, n == 0, LOOKUP_COMMAND_STATUS_ADDR, 32'h00000002);
      idle(2);
      n++;
    end while (last_rdata !== 32'h00000000 && n < 20);
    if (n >= 20) check(last_rdata, 32'h00000000);
    rd(LOOKUP_READ_DATA_LOW_ADDR, lo);
    rd(LOOKUP_READ_DATA_HIGH_ADDR, hi & HI_WRITE_MASK);
    wr(LOOKUP_TABLE_COMMAND_ADDR, 32'h00000000);
    rd(LOOKUP_READ_DATA_LOW_ADDR, lo);
    idle(1);
  endtask

  task automatic look(input logic [31:0] lo, input logic [31:0] hi, input logic hit,
                      input logic filt, input logic [2:0] port);
    dest_mac_in <= {hi[15:0], lo};
    idle(3);
    lk_q.push_back({hit, filt, port});
    lk_chk <= 1'b1;
    idle(1);
    lk_chk <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #(5000 * 40);
    fails++;
    print_verdict();
  end

  initial begin
    lo_a = $random(seed) | 32'h00000001;
    lo_b = $random(seed) & 32'hFFFFFFFE;
    lo_c = $random(seed);
    lo_d = $random(seed);
    lo_r = $random(seed);
    hi_a = 32'h05010000 | ($random(seed) & 32'h0000FFFF);
    hi_b = 32'h05860000 | ($random(seed) & 32'h0000FFFF);
    hi_c = 32'h06030000 | ($random(seed) & 32'h0000FFFF);
    hi_d = 32'h06020000 | ($random(seed) & 32'h0000FFFF);
    repeat (4) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    rd(LOOKUP_TABLE_COMMAND_ADDR, 32'h00000000);
    rd(LOOKUP_WRITE_DATA_LOW_ADDR, 32'h00000000);
    rd(LOOKUP_WRITE_DATA_HIGH_ADDR, 32'h00000000);
    rd(LOOKUP_READ_DATA_LOW_ADDR, 32'h00000000);
    rd(LOOKUP_READ_DATA_HIGH_ADDR, 32'h00000000);
    rd(LOOKUP_COMMAND_STATUS_ADDR, 32'h00000000);
    rd(16'h1805, 32'h00000000);
    wr(LOOKUP_WRITE_DATA_LOW_ADDR, lo_r);
    wr(LOOKUP_WRITE_DATA_HIGH_ADDR, 32'hFFFFFFFF);
    rd(LOOKUP_WRITE_DATA_LOW_ADDR, lo_r);
    rd(LOOKUP_WRITE_DATA_HIGH_ADDR, HI_WRITE_MASK);
    // Zero command bits start neither a make nor a search
    wr(LOOKUP_TABLE_COMMAND_ADDR, 32'h00000000);
    rd(LOOKUP_COMMAND_STATUS_ADDR, 32'h00000000);
    idle(1);
    look(lo_r, 32'h0000FFFF, 1'b0, 1'b0, 3'h0);
    make(lo_a, hi_a);
    make(lo_b, hi_b);
    look(lo_a, hi_a, 1'b1, 1'b0, 3'h1);
    look(lo_b, hi_b, 1'b1, 1'b1, 3'h6);
    get(32'h00000002, lo_a, hi_a);
    get(32'h00000001, lo_b, hi_b);
    get(32'h00000001, 32'h00000000, 32'h00000000);
    get(32'h00000002, lo_a, hi_a);
    // Replace one entry with a filtering one, then remove the other
    make(lo_a, hi_a | 32'h00800000);
    look(lo_a, hi_a, 1'b1, 1'b1, 3'h1);
    make(lo_b, hi_b & 32'hFBFFFFFF);
    look(lo_b, hi_b, 1'b0, 1'b0, 3'h0);
    make(lo_c, hi_c);
    make(lo_d, hi_d);
    look(lo_d, hi_d, 1'b1, 1'b0, 3'h2);
    // Refresh only one of the two aging entries across several aging ticks
    for (i = 0; i < 40; i++) begin
      src_mac_in  <= {hi_c[15:0], lo_c};
      src_seen_in <= 1'b1;
      idle(1);
      src_seen_in <= 1'b0;
      idle(9);
    end
    look(lo_c, hi_c, 1'b1, 1'b0, 3'h3);
    look(lo_d, hi_d, 1'b0, 1'b0, 3'h0);
    look(lo_a, hi_a, 1'b1, 1'b1, 3'h1);
    idle(2);
    print_verdict();
  end
endmodule
`default_nettype wire
